/* File: scs_pkg.sv */
// Constants and types for the system clock source selector.
// Assumes a single SYS_CLK domain; all clock sources arrive as sampled pins.
package scs_pkg;
   localparam int DIV_W = 10;
   localparam int SRC_N = 5;
   localparam real SYS_CLK_PERIOD_NS = 20.0;
   localparam logic [1:0] SEL_WAKEUP = 2'h0;
   localparam logic [1:0] SEL_RESERVED = 2'h1;
   localparam logic [1:0] SEL_LOOP_OR_PRESC = 2'h2;
   localparam logic [1:0] SEL_DIRECT = 2'h3;
   localparam int IDX_WAKEUP = 0;
   localparam int IDX_PLL = 1;
   localparam int IDX_CRYSTAL = 2;
   localparam int IDX_INT_OSC = 3;
   localparam int IDX_DIRECT = 4;
   localparam logic [DIV_W-1:0] CNT_RESET = 10'h000;
   localparam logic [DIV_W-1:0] DIV_RESET = 10'h000;
   localparam logic CLK_OUT_RESET = 1'b0;
   localparam logic PLL_EN_RESET = 1'b0;
   typedef enum logic [3:0]
   {
      SCS_SRC_WAKE = 4'h1,
      SCS_SRC_PLL = 4'h2,
      SCS_SRC_PRESC = 4'h4,
      SCS_SRC_DIRECT = 4'h8
   } scs_src_e;
   localparam scs_src_e SRC_RESET = SCS_SRC_WAKE;
endpackage

/* File: scs_sync.sv */
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit is an unrelated asynchronous level; no bus coherence.
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb
   begin
      meta_nxt = d;
      q_nxt = meta_r;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q = q_r;
endmodule
`default_nettype wire

/* File: scs_system_clock_source_select.sv */
// System clock source selector with output prescaler.
// Assumes every source toggles below half of SYS_CLK; sources are sampled, so edges jitter by one cycle.
`timescale 1ns/1ps
`default_nettype none
module scs_system_clock_source_select
   import scs_pkg::*;
#(
   parameter int DIV_W = scs_pkg::DIV_W
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic DIRECT_CLOCK_INPUT_PIN,
   input wire logic CRYSTAL_INPUT_PIN,
   input wire logic INT_OSC_CLK,
   input wire logic PLL_CLK,
   input wire logic WAKEUP_CLK,
   input wire logic [1:0] SYSTEM_CLOCK_SOURCE_SELECT,
   input wire logic VCO_BYPASS,
   input wire logic OSC_USE_INTERNAL,
   input wire logic [DIV_W-1:0] OUTPUT_PRESCALER_DIVIDER_FIELD,
   output logic SYS_CLK_OUT,
   output logic PLL_ENABLE,
   output logic [3:0] SOURCE_ACTIVE
);
   logic [SRC_N-1:0] src_raw;
   logic [SRC_N-1:0] src_s;
   logic osc_s;
   logic osc_prev_r;
   logic osc_prev_nxt;
   logic osc_rise;
   logic wrap;
   logic [DIV_W-1:0] cnt_r;
   logic [DIV_W-1:0] cnt_nxt;
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] div_nxt;
   logic [DIV_W:0] half_w;
   logic presc_val;
   scs_src_e state_r;
   scs_src_e state_nxt;
   scs_src_e req;
   logic req_val;
   logic clk_out_r;
   logic clk_out_nxt;
   logic pll_en_r;
   logic pll_en_nxt;

   assign src_raw[IDX_WAKEUP] = WAKEUP_CLK;
   assign src_raw[IDX_PLL] = PLL_CLK;
   assign src_raw[IDX_CRYSTAL] = CRYSTAL_INPUT_PIN;
   assign src_raw[IDX_INT_OSC] = INT_OSC_CLK;
   assign src_raw[IDX_DIRECT] = DIRECT_CLOCK_INPUT_PIN;

   scs_sync #(
      .W(SRC_N)
   ) u_sync (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .d(src_raw),
      .q(src_s)
   );

   // Prescaler input: crystal or internal oscillator
   assign osc_s = OSC_USE_INTERNAL ? src_s[IDX_INT_OSC] : src_s[IDX_CRYSTAL];
   assign osc_rise = osc_s && !osc_prev_r;
   assign wrap = osc_rise && (cnt_r == div_r);
   // High for the first ceil(K/2) oscillator periods of each output period
   assign half_w = ({1'b0, div_r} + (DIV_W + 1)'(2)) >> 1;

   always_comb
   begin
      osc_prev_nxt = osc_s;
      cnt_nxt = cnt_r;
      div_nxt = div_r;
      if (wrap)
      begin
         cnt_nxt = CNT_RESET;
         // New factor only at a period boundary, so no runt pulse appears
         div_nxt = OUTPUT_PRESCALER_DIVIDER_FIELD;
      end
      else if (osc_rise)
      begin
         cnt_nxt = cnt_r + DIV_W'(1);
      end
   end

   always_comb
   begin
      if (div_r == '0)
      begin
         presc_val = osc_s;
      end
      else
      begin
         presc_val = ({1'b0, cnt_r} < half_w);
      end
   end

   // Requested source from the control inputs; reserved code keeps the present one
   always_comb
   begin
      case (SYSTEM_CLOCK_SOURCE_SELECT)
         SEL_DIRECT: req = SCS_SRC_DIRECT;
         SEL_LOOP_OR_PRESC: req = VCO_BYPASS ? SCS_SRC_PRESC : SCS_SRC_PLL;
         SEL_WAKEUP: req = SCS_SRC_WAKE;
         default: req = state_r;
      endcase
   end

   always_comb
   begin
      case (req)
         SCS_SRC_WAKE: req_val = src_s[IDX_WAKEUP];
         SCS_SRC_PLL: req_val = src_s[IDX_PLL];
         SCS_SRC_PRESC: req_val = presc_val;
         SCS_SRC_DIRECT: req_val = src_s[IDX_DIRECT];
         default: req_val = 1'b0;
      endcase
   end

   always_comb
   begin
      state_nxt = state_r;
      // Switch only while both old output and new source are low: no glitch, at most one stretched low
      if (req != state_r && !clk_out_r && !req_val)
      begin
         state_nxt = req;
      end
      case (state_nxt)
         SCS_SRC_WAKE: clk_out_nxt = src_s[IDX_WAKEUP];
         SCS_SRC_PLL: clk_out_nxt = src_s[IDX_PLL];
         SCS_SRC_PRESC: clk_out_nxt = presc_val;
         SCS_SRC_DIRECT: clk_out_nxt = src_s[IDX_DIRECT];
         default: clk_out_nxt = 1'b0;
      endcase
      // Loop runs before it is switched in and while it drives
      pll_en_nxt = (req == SCS_SRC_PLL) || (state_nxt == SCS_SRC_PLL);
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         osc_prev_r <= 1'b0;
         cnt_r <= CNT_RESET;
         div_r <= DIV_RESET;
         state_r <= SRC_RESET;
         clk_out_r <= CLK_OUT_RESET;
         pll_en_r <= PLL_EN_RESET;
      end
      else
      begin
         osc_prev_r <= osc_prev_nxt;
         cnt_r <= cnt_nxt;
         div_r <= div_nxt;
         state_r <= state_nxt;
         clk_out_r <= clk_out_nxt;
         pll_en_r <= pll_en_nxt;
      end
   end

   assign SYS_CLK_OUT = clk_out_r;
   assign PLL_ENABLE = pll_en_r;
   assign SOURCE_ACTIVE = state_r;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   sequence s_stay_direct;
      state_r == SCS_SRC_DIRECT && state_nxt == SCS_SRC_DIRECT;
   endsequence

   property p_direct_pass;
      s_stay_direct |=> clk_out_r == $past(src_s[IDX_DIRECT]);
   endproperty
   a_direct_pass: assert property (p_direct_pass) else $error("direct clock not passed");

   property p_presc_pass;
      (state_r == SCS_SRC_PRESC && state_nxt == SCS_SRC_PRESC) |=> clk_out_r == $past(presc_val);
   endproperty
   a_presc_pass: assert property (p_presc_pass) else $error("prescaler output not selected");

   property p_presc_req;
      (SYSTEM_CLOCK_SOURCE_SELECT == SEL_LOOP_OR_PRESC && VCO_BYPASS) |-> req == SCS_SRC_PRESC;
   endproperty
   a_presc_req: assert property (p_presc_req) else $error("bypass request wrong");

   sequence s_wrap;
      wrap;
   endsequence

   sequence s_count;
      osc_rise && !wrap;
   endsequence

   property p_wrap;
      s_wrap |=> cnt_r == '0 && div_r == $past(OUTPUT_PRESCALER_DIVIDER_FIELD);
   endproperty
   a_wrap: assert property (p_wrap) else $error("prescaler wrap wrong");

   property p_count;
      s_count |=> cnt_r == $past(cnt_r) + DIV_W'(1) && $stable(div_r);
   endproperty
   a_count: assert property (p_count) else $error("prescaler count wrong");

   property p_unity;
      (div_r == '0 && state_r == SCS_SRC_PRESC && state_nxt == SCS_SRC_PRESC) |=> clk_out_r == $past(osc_s);
   endproperty
   a_unity: assert property (p_unity) else $error("unity factor not passthrough");

   property p_range;
      cnt_r <= div_r;
   endproperty
   a_range: assert property (p_range) else $error("count beyond factor");

   property p_pll_en;
      (req == SCS_SRC_PLL) |=> PLL_ENABLE;
   endproperty
   a_pll_en: assert property (p_pll_en) else $error("loop not enabled");

   property p_pll_pass;
      (state_r == SCS_SRC_PLL && state_nxt == SCS_SRC_PLL) |=> clk_out_r == $past(src_s[IDX_PLL]) && PLL_ENABLE;
   endproperty
   a_pll_pass: assert property (p_pll_pass) else $error("loop clock not passed");

   property p_wake_pass;
      (state_r == SCS_SRC_WAKE && state_nxt == SCS_SRC_WAKE) |=> clk_out_r == $past(src_s[IDX_WAKEUP]);
   endproperty
   a_wake_pass: assert property (p_wake_pass) else $error("wakeup clock not passed");

   property p_switch_low;
      $changed(state_r) |-> !clk_out_r && !$past(clk_out_r);
   endproperty
   a_switch_low: assert property (p_switch_low) else $error("source switched while high");

   property p_div_change;
      $changed(div_r) |-> $past(wrap);
   endproperty
   a_div_change: assert property (p_div_change) else $error("factor changed mid period");
endmodule
`default_nettype wire

/* File: scs_system_clock_source_select_tb_top.sv */
// Testbench for the system clock source selector.
// Assumes source clocks toggle on SYS_CLK falling edges, so periods measure to one cycle.
`timescale 1ns/1ps
`default_nettype none
module scs_system_clock_source_select_tb_top;
   import scs_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dir_c = 1'b0;
   logic xtal_c = 1'b0;
   logic osc_c = 1'b0;
   logic pll_c = 1'b0;
   logic wake_c = 1'b0;
   logic [1:0] sel = 2'h0;
   logic byp = 1'b0;
   logic use_int = 1'b0;
   logic [DIV_W-1:0] div = 10'h000;
   logic clk_out;
   logic pll_en;
   logic [3:0] src;
   logic last = 1'b0;
   int err_count = 0;
   int tests_run = 0;
   int run = 0;

   scs_system_clock_source_select u_dut (
      .SYS_CLK(clk),
      .RST_N(rst_n),
      .DIRECT_CLOCK_INPUT_PIN(dir_c),
      .CRYSTAL_INPUT_PIN(xtal_c),
      .INT_OSC_CLK(osc_c),
      .PLL_CLK(pll_c),
      .WAKEUP_CLK(wake_c),
      .SYSTEM_CLOCK_SOURCE_SELECT(sel),
      .VCO_BYPASS(byp),
      .OSC_USE_INTERNAL(use_int),
      .OUTPUT_PRESCALER_DIVIDER_FIELD(div),
      .SYS_CLK_OUT(clk_out),
      .PLL_ENABLE(pll_en),
      .SOURCE_ACTIVE(src)
   );

   initial
   begin
      forever #(SYS_CLK_PERIOD_NS / 2.0) clk = ~clk;
   end
   always #200 wake_c = ~wake_c;
   always #60 pll_c = ~pll_c;
   always #120 osc_c = ~osc_c;
   // Uneven duty on direct and crystal so duty passing is visible
   always
   begin
      #140 dir_c = 1'b1;
      #60 dir_c = 1'b0;
   end
   always
   begin
      #100 xtal_c = 1'b1;
      #60 xtal_c = 1'b0;
   end

   task automatic fail(input string m);
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic chk_val(input logic [3:0] g, input logic [3:0] e, input string m);
      tests_run++;
      if (g !== e)
         fail(m);
   endtask

   // Sampling of async sources allows one cycle of slack
   task automatic chk_cnt(input int g, input int e, input string m);
      tests_run++;
      if (g < e - 1 || g > e + 1)
         fail(m);
   endtask

   task automatic edge_wait(input logic v);
      int n;
      n = 0;
      while (clk_out !== v && n < 20000)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000)
         fail("no output edge");
   endtask

   task automatic measure(input int h, input int p, input string m);
      int c;
      repeat (2)
      begin
         edge_wait(1'b0);
         edge_wait(1'b1);
      end
      c = 0;
      while (clk_out === 1'b1 && c < 20000)
      begin
         @(negedge clk);
         c++;
      end
      chk_cnt(c, h, m);
      while (clk_out === 1'b0 && c < 40000)
      begin
         @(negedge clk);
         c++;
      end
      chk_cnt(c, p, m);
   endtask

   task automatic setup(input logic [1:0] s, input logic b, input logic i, input logic [DIV_W-1:0] d);
      @(negedge clk);
      sel = s;
      byp = b;
      use_int = i;
      div = d;
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Any output phase under two cycles means a switch glitched
   always @(negedge clk)
   begin
      if (clk_out !== last)
      begin
         if (rst_n === 1'b1 && run < 2)
            fail("short output phase");
         run = 1;
         last = clk_out;
      end
      else
         run++;
   end

   initial
   begin
      #(60000 * 20);
      fail("watchdog expired");
      close_out;
   end

   task automatic sc_reset_start;
      repeat (20) @(negedge clk);
      chk_val({clk_out, pll_en, 2'h0}, 4'h0, "reset outputs");
      chk_val(src, SRC_RESET, "reset source");
      rst_n = 1'b1;
   endtask

   task automatic sc_wakeup;
      measure(10, 20, "wakeup timing");
      chk_val(src, SCS_SRC_WAKE, "wakeup source");
   endtask

   task automatic sc_direct;
      setup(SEL_DIRECT, 1'b0, 1'b0, 10'h000);
      measure(3, 10, "direct timing");
      chk_val(src, SCS_SRC_DIRECT, "direct source");
   endtask

   // Reset in mid-run with direct drive still selected: restart from wakeup, then switch again
   task automatic sc_mid_reset;
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk_val({clk_out, pll_en, 2'h0}, 4'h0, "mid-run reset outputs");
      chk_val(src, SRC_RESET, "mid-run reset source");
      rst_n = 1'b1;
      measure(3, 10, "direct after reset");
      chk_val(src, SCS_SRC_DIRECT, "direct source after reset");
   endtask

   task automatic sc_reserved;
      setup(SEL_RESERVED, 1'b0, 1'b0, 10'h000);
      measure(3, 10, "reserved select timing");
      chk_val(src, SCS_SRC_DIRECT, "reserved select source");
   endtask

   task automatic sc_loop;
      setup(SEL_LOOP_OR_PRESC, 1'b0, 1'b0, 10'h000);
      measure(3, 6, "loop timing");
      chk_val({3'h0, pll_en}, 4'h1, "loop enable");
      chk_val(src, SCS_SRC_PLL, "loop source");
   endtask

   task automatic sc_unity;
      setup(SEL_LOOP_OR_PRESC, 1'b1, 1'b0, 10'h000);
      measure(3, 8, "unity crystal duty");
      chk_val(src, SCS_SRC_PRESC, "prescaler source");
   endtask

   task automatic sc_int_by_four;
      setup(SEL_LOOP_OR_PRESC, 1'b1, 1'b1, 10'h003);
      measure(24, 48, "internal osc by four");
   endtask

   task automatic sc_xtal_by_three;
      setup(SEL_LOOP_OR_PRESC, 1'b1, 1'b0, 10'h002);
      measure(16, 24, "crystal by three");
   endtask

   task automatic sc_largest;
      setup(SEL_LOOP_OR_PRESC, 1'b1, 1'b0, 10'h3ff);
      measure(4096, 8192, "largest factor");
   endtask

   task automatic sc_return_wakeup;
      setup(SEL_WAKEUP, 1'b0, 1'b0, 10'h000);
      measure(10, 20, "return to wakeup");
      chk_val(src, SCS_SRC_WAKE, "wakeup source again");
      chk_val({3'h0, pll_en}, 4'h0, "loop released");
   endtask

   initial
   begin
      sc_reset_start;
      sc_wakeup;
      sc_direct;
      sc_mid_reset;
      sc_reserved;
      sc_loop;
      sc_unity;
      sc_int_by_four;
      sc_xtal_by_three;
      sc_largest;
      sc_return_wakeup;
      close_out;
   end
endmodule
`default_nettype wire
